//--- verilog/bpm_mode_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - In PWM, one switch pulse starts every clock manager period.
// - In PWM, the duty comparator trip ends the pulse.
// - In PWM, the switch may stay on all period; current limit still acts.
// - Peak-current flag ends a pulse at once; next pulse starts normally.
// - Duty-trip pulses shorter than minimum on-time are stretched to exactly minimum; a peak-current cut is not.
// - Entry threshold reached in PWM moves the controller to PFM.
// - Automatic PFM entry cannot be disabled.
// - In PFM the driver stays off except during charging pulses.
// - In PFM, output at light-load reference fires one minimum pulse.
// - Entering PFM selects the light-load reference.
// - PFM pulse rate above exit threshold returns control to PWM.
// - Exit threshold is 1.20 times the clock manager frequency.
// - Logic runs from the clock manager: internal or external timing.
// - External sync paces pulses only in soft start and PWM; in PFM it only sets the period for the exit threshold.
// - Supply-low flag stops switching and holds shutdown.
// - Thermal trip switches off; restart after cooling.
// - Every start runs the soft-start ramp.
module bpm_mode_ctrl
  import bpm_pkg::*;
#(
  parameter int unsigned SOFT_CYC = SOFT_START_CYC,
  parameter int unsigned MINON_CYC = MIN_ON_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic turnOn,
  input wire logic supplyLow,
  input wire logic thermalTrip,
  input wire logic oscTick,
  input wire logic extSync,
  input wire logic extSyncSel,
  input wire logic dutyTrip,
  input wire logic peakCurrent,
  input wire logic entryThreshold,
  input wire logic lightLoadLow,
  output logic driverOn,
  output logic stageEnable,
  output logic lightLoadRefSel,
  output logic softStartActive,
  output logic pfmMode,
  output logic [1:0] modeState
);

  // ----------------------------------------------------------------------
  // Input conditioning.
  // ----------------------------------------------------------------------
  logic enLvl;
  logic uvLvl;
  logic otLvl;
  logic dutyLvl;
  logic peakLvl;
  logic entryLvl;
  logic llRise;
  logic syncRise;
  logic oscRise;

  // Analog flags and pins arrive asynchronously; each settles in three stages.
  bpm_sync uEn (.clock(clock), .rst(rst), .din(turnOn), .dout(enLvl));
  bpm_sync uUv (.clock(clock), .rst(rst), .din(supplyLow), .dout(uvLvl));
  bpm_sync uOt (.clock(clock), .rst(rst), .din(thermalTrip), .dout(otLvl));
  bpm_sync uDuty (.clock(clock), .rst(rst), .din(dutyTrip), .dout(dutyLvl));
  bpm_sync uPeak (.clock(clock), .rst(rst), .din(peakCurrent), .dout(peakLvl));
  bpm_sync uEntry (.clock(clock), .rst(rst), .din(entryThreshold), .dout(entryLvl));
  // Only the edges of these three are used; their settled levels are left open.
  bpm_edge_sync uLl (.clock(clock), .rst(rst), .din(lightLoadLow),
                     .level(), .rise(llRise));
  bpm_edge_sync uSyn (.clock(clock), .rst(rst), .din(extSync),
                      .level(), .rise(syncRise));
  bpm_edge_sync uOsc (.clock(clock), .rst(rst), .din(oscTick),
                      .level(), .rise(oscRise));

  // ----------------------------------------------------------------------
  // Clock manager period tick and fault summary.
  // ----------------------------------------------------------------------
  logic periodTick;
  logic fault;

  always_comb begin
    periodTick = extSyncSel ? syncRise : oscRise;
    fault = ~enLvl | uvLvl | otLvl;
  end

  // ----------------------------------------------------------------------
  // Controller state.
  // ----------------------------------------------------------------------
  typedef struct packed {
    bpm_state_e state;
    logic drive;
    logic [CNT_W-1:0] onCnt;
    logic [CNT_W-1:0] softCnt;
    logic [CNT_W-1:0] gapCnt;
    logic [CNT_W-1:0] periodCnt;
    logic [CNT_W-1:0] periodLen;
    logic pfm;
  } bpm_ctrl_s;

  bpm_ctrl_s st_r;
  bpm_ctrl_s st_nxt;

  logic minDone;
  logic [CNT_W+3:0] gapX12;
  logic [CNT_W+3:0] periodX10;

  // Next-state logic: pulse timing, mode selection and shutdown.
  always_comb begin
    st_nxt = st_r;
    // At this edge the pulse has already been on for onCnt + 1 cycles.
    minDone = (st_r.onCnt >= CNT_W'(MINON_CYC - 1));
    gapX12 = {4'h0, st_r.gapCnt} * (CNT_W+4)'(EXIT_RATIO_X10);
    periodX10 = {4'h0, st_r.periodLen} * (CNT_W+4)'(10);
    // The period length of the clock manager is measured in every state.
    if (periodTick) begin
      st_nxt.periodCnt = '0;
      st_nxt.periodLen = st_r.periodCnt + CNT_W'(1);
    end else if (st_r.periodCnt != '1) begin
      st_nxt.periodCnt = st_r.periodCnt + CNT_W'(1);
    end
    if (st_r.drive && st_r.onCnt != '1) begin
      st_nxt.onCnt = st_r.onCnt + CNT_W'(1);
    end
    if (st_r.gapCnt != '1) begin
      st_nxt.gapCnt = st_r.gapCnt + CNT_W'(1);
    end
    if (fault) begin
      // Any shutdown drops the pulse and rearms a full soft start.
      st_nxt.state = BPM_OFF;
      st_nxt.drive = 1'b0;
      st_nxt.pfm = RESET_MODE_PFM;
      st_nxt.softCnt = '0;
    end else begin
      case (st_r.state)
        BPM_OFF: begin
          st_nxt.state = BPM_SOFT;
          st_nxt.softCnt = '0;
          st_nxt.pfm = 1'b0;
        end
        BPM_SOFT, BPM_PWM: begin
          // The ramp runs alongside PWM switching until it expires.
          if (st_r.state == BPM_SOFT) begin
            if (st_r.softCnt >= CNT_W'(SOFT_CYC - 1)) begin
              st_nxt.state = BPM_PWM;
            end else begin
              st_nxt.softCnt = st_r.softCnt + CNT_W'(1);
            end
          end
          if (st_r.drive) begin
            if (peakLvl) begin
              st_nxt.drive = 1'b0;
            end else if (dutyLvl && minDone) begin
              st_nxt.drive = 1'b0;
            end
          end
          // A period start with the switch still on keeps it on for 100% duty,
          // without restarting the on-time, so a settled duty trip still ends it.
          // Peak current never holds a pulse back; it only cuts it, cycle by cycle.
          if (periodTick) begin
            st_nxt.drive = 1'b1;
            if (!st_r.drive) begin
              st_nxt.onCnt = '0;
            end
          end
          // Entry cannot be masked; it doubles as overvoltage protection.
          if (entryLvl && st_r.state == BPM_PWM) begin
            st_nxt.state = BPM_PFM;
            st_nxt.pfm = 1'b1;
            st_nxt.drive = st_r.drive && !minDone;
            st_nxt.gapCnt = '1;
          end
        end
        BPM_PFM: begin
          // Period ticks and sync edges are ignored here.
          if (st_r.drive) begin
            if (peakLvl || minDone) begin
              st_nxt.drive = 1'b0;
            end
          end else if (llRise) begin
            st_nxt.drive = 1'b1;
            st_nxt.onCnt = '0;
            st_nxt.gapCnt = '0;
            // Rate above 1.2x the clock manager rate: gap*1.2 shorter than one period.
            if (st_r.gapCnt != '1 && gapX12 < periodX10) begin
              st_nxt.state = BPM_PWM;
              st_nxt.pfm = 1'b0;
            end
          end
        end
        default: begin
          st_nxt.state = BPM_OFF;
          st_nxt.drive = 1'b0;
        end
      endcase
    end
  end

  // Register the whole state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{state: BPM_OFF, drive: 1'b0, onCnt: '0, softCnt: '0,
                gapCnt: '1, periodCnt: '0, periodLen: '1, pfm: RESET_MODE_PFM};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops.
  // ----------------------------------------------------------------------
  // In PFM the stage is enabled only while each charging pulse is on.
  always_comb begin
    driverOn = st_r.drive;
    stageEnable = st_r.pfm ? st_r.drive : (st_r.state != BPM_OFF);
    lightLoadRefSel = st_r.pfm;
    softStartActive = (st_r.state == BPM_SOFT);
    pfmMode = st_r.pfm;
    modeState = st_r.state;
  end

endmodule : bpm_mode_ctrl

//--- verilog/bpm_pkg.sv
package bpm_pkg;

  // ----------------------------------------------------------------------
  // Timing at the 25 MHz controller clock.
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Minimum switch on-time in ns; a least time, so it rounds up.
  localparam int unsigned MIN_ON_NS = 100;
  localparam int unsigned MIN_ON_CYC =
      (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Soft-start ramp duration in us (typical figure).
  localparam int unsigned SOFT_START_US = 450;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * 1000 / CLK_PERIOD_NS;
  // Exit frequency ratio 1.20 held as tenths of the clock manager frequency.
  localparam int unsigned EXIT_RATIO_X10 = 12;

  // ----------------------------------------------------------------------
  // Widths and reset values.
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam logic RESET_MODE_PFM = 1'b0;

  // Operating states of the controller.
  typedef enum logic [1:0] {
    BPM_OFF = 2'b00,
    BPM_SOFT = 2'b01,
    BPM_PWM = 2'b10,
    BPM_PFM = 2'b11
  } bpm_state_e;

endpackage : bpm_pkg

//--- verilog/bpm_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages one and two agree.
module bpm_sync
  import bpm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic [2:0] stg;
    logic out;
  } bpm_sync_s;

  bpm_sync_s st_r;
  bpm_sync_s st_nxt;

  // Shift the pin in; stage zero feeds only stage one.
  always_comb begin
    st_nxt = st_r;
    st_nxt.stg = {st_r.stg[1:0], din};
    if (st_r.stg[1] == st_r.stg[2]) begin
      st_nxt.out = st_r.stg[2];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.out;

endmodule : bpm_sync

//--- verilog/bpm_edge_sync.sv
`timescale 1ns/1ps
// Synchronised pin with a one-cycle pulse on each rising edge of the settled level.
module bpm_edge_sync
  import bpm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise
);

  logic lvl;
  logic lvlDly_r;

  bpm_sync uSync (
    .clock(clock),
    .rst(rst),
    .din(din),
    .dout(lvl)
  );

  // Delay the settled level for edge detection.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lvlDly_r <= 1'b0;
    end else begin
      lvlDly_r <= lvl;
    end
  end

  assign level = lvl;
  assign rise = lvl & ~lvlDly_r;

endmodule : bpm_edge_sync

//--- testbench/bpm_mode_ctrl_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker of the mode controller.
// ----------------------------------------------------------------------
module bpm_mode_checker #(
  parameter int unsigned SOFT_CYC = 20,
  parameter int unsigned MINON_CYC = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic turnOn,
  input wire logic supplyLow,
  input wire logic thermalTrip,
  input wire logic oscTick,
  input wire logic extSync,
  input wire logic extSyncSel,
  input wire logic dutyTrip,
  input wire logic peakCurrent,
  input wire logic entryThreshold,
  input wire logic lightLoadLow,
  input wire logic driverOn,
  input wire logic stageEnable,
  input wire logic lightLoadRefSel,
  input wire logic softStartActive,
  input wire logic pfmMode,
  input wire logic [1:0] modeState
);
  logic [7:0] onLen;
  logic [7:0] calm;
  logic [7:0] llAge;
  // Saturating ages; a pulse may end early only after a known cause.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      onLen <= 8'h00;
      calm <= 8'h00;
      llAge <= 8'hff;
    end else begin
      onLen <= driverOn ? onLen + 8'(onLen != 8'hff) : 8'h00;
      calm <= (peakCurrent || supplyLow || thermalTrip || !turnOn) ? 8'h00
          : calm + 8'(calm != 8'hff);
      llAge <= lightLoadLow ? 8'h00 : llAge + 8'(llAge != 8'hff);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Settled cause while the switch is still on.
  sequence s_peakOn;
    peakCurrent[*6] ##0 driverOn;
  endsequence
  sequence s_tripOn;
    dutyTrip[*6] ##0 (driverOn && onLen > 8'h04);
  endsequence
  a_pfm_flag: assert property (pfmMode == (modeState == 2'h3))
    else $error("pfm flag disagrees with state");
  a_ref_select: assert property (lightLoadRefSel == pfmMode)
    else $error("reference select wrong");
  a_soft_flag: assert property (softStartActive == (modeState == 2'h1))
    else $error("soft start flag wrong");
  a_pfm_stage: assert property (pfmMode && !driverOn |-> !stageEnable)
    else $error("stage enabled between pfm pulses");
  a_off_quiet: assert property (modeState == 2'h0 |-> !driverOn && !stageEnable)
    else $error("switching while shut down");
  a_peak_cut: assert property (s_peakOn |=> !driverOn)
    else $error("pulse not cut on peak current");
  a_trip_end: assert property (s_tripOn |=> !driverOn)
    else $error("pulse not ended by duty trip");
  a_min_on: assert property ($fell(driverOn) && calm > 8'h0c &&
      $past(modeState, 2) == modeState |-> onLen >= 8'(MINON_CYC))
    else $error("pulse shorter than minimum");
  a_pfm_demand: assert property (pfmMode && $past(pfmMode) && $rose(driverOn)
      |-> llAge < 8'h08)
    else $error("pfm pulse without demand");
endmodule : bpm_mode_checker

bind bpm_mode_ctrl bpm_mode_checker #(.SOFT_CYC(SOFT_CYC), .MINON_CYC(MINON_CYC)) chk_u (
  .clock(clock), .rst(rst), .turnOn(turnOn), .supplyLow(supplyLow),
  .thermalTrip(thermalTrip), .oscTick(oscTick), .extSync(extSync),
  .extSyncSel(extSyncSel), .dutyTrip(dutyTrip), .peakCurrent(peakCurrent),
  .entryThreshold(entryThreshold), .lightLoadLow(lightLoadLow), .driverOn(driverOn),
  .stageEnable(stageEnable), .lightLoadRefSel(lightLoadRefSel),
  .softStartActive(softStartActive), .pfmMode(pfmMode), .modeState(modeState));

//--- testbench/bpm_analog_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Oscillator and duty comparator on the analog side.
// ----------------------------------------------------------------------
module bpm_analog_model #(
  parameter int OSC_CYC = 20
) (
  input wire logic clock,
  input wire logic driverOn,
  input wire logic [7:0] tripCyc,
  output logic oscTick = 1'b0,
  output logic dutyTrip = 1'b0
);
  int ph = 0;
  int on = 0;
  // The ramp restarts each pulse; zero means the loop wants less than any pulse.
  always @(posedge clock) begin
    ph <= (ph + 1) % OSC_CYC;
    on <= driverOn ? on + 1 : 0;
    oscTick <= ph < OSC_CYC / 2;
    dutyTrip <= tripCyc == 8'h00 || (driverOn && on >= int'(tripCyc));
  end
endmodule : bpm_analog_model

//--- testbench/bpm_mode_ctrl_tb.sv
`timescale 1ns/1ps
module bpm_mode_ctrl_tb;
  localparam int MINON = bpm_pkg::MIN_ON_CYC;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic turnOn = 1'b0, supplyLow = 1'b0, thermalTrip = 1'b0, extSyncSel = 1'b0;
  logic peakCurrent = 1'b0, entryThreshold = 1'b0, lightLoadLow = 1'b0;
  logic [7:0] tripCyc = 8'h06;
  logic [3:0] syncCnt = 4'h0;
  logic oscTick, dutyTrip, driverOn, stageEnable, lightLoadRefSel, softStartActive, pfmMode;
  logic [1:0] modeState;
  logic [7:0] c, w;
  int mismatches = 0;
  int checksDone = 0;
  int cyc = 0;
  wire extSync = syncCnt[3];
  bpm_analog_model osc_u (.clock(clock), .driverOn(driverOn), .tripCyc(tripCyc),
    .oscTick(oscTick), .dutyTrip(dutyTrip));
  bpm_mode_ctrl #(.SOFT_CYC(20), .MINON_CYC(MINON)) dut_u (.clock(clock), .rst(rst),
    .turnOn(turnOn), .supplyLow(supplyLow), .thermalTrip(thermalTrip), .oscTick(oscTick),
    .extSync(extSync), .extSyncSel(extSyncSel), .dutyTrip(dutyTrip),
    .peakCurrent(peakCurrent), .entryThreshold(entryThreshold), .lightLoadLow(lightLoadLow),
    .driverOn(driverOn), .stageEnable(stageEnable), .lightLoadRefSel(lightLoadRefSel),
    .softStartActive(softStartActive), .pfmMode(pfmMode), .modeState(modeState));
  always #20 clock = ~clock;
  // External sync of period 16 and the hang limit, well above the ~900 cycles needed.
  always @(posedge clock) begin
    syncCnt <= syncCnt + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic waitMode(input logic [1:0] m);
    for (int i = 0; i < 200 && modeState !== m; i++) @(negedge clock);
    chk(8'(modeState), 8'(m));
  endtask : waitMode
  task automatic pulse(output logic [7:0] n);
    n = 8'h00;
    // A pulse already in flight is skipped; only a whole pulse is measured.
    for (int i = 0; i < 100 && driverOn !== 1'b0; i++) @(negedge clock);
    for (int i = 0; i < 100 && driverOn !== 1'b1; i++) @(negedge clock);
    while (driverOn === 1'b1 && n != 8'hff) begin
      n++;
      @(negedge clock);
    end
  endtask : pulse
  task automatic rises(input int n, output logic [7:0] k);
    logic p;
    k = 8'h00;
    p = driverOn;
    repeat (n) begin
      @(negedge clock);
      if (driverOn && !p) k++;
      p = driverOn;
    end
  endtask : rises
  // Demand pulse held long enough for the synchroniser, then a gap.
  task automatic fire(input int gap);
    fork
      begin
        @(posedge clock) lightLoadLow <= 1'b1;
        repeat (6) @(posedge clock);
        lightLoadLow <= 1'b0;
      end
      pulse(w);
    join
    repeat (gap) @(posedge clock);
  endtask : fire
  task automatic t_start;
    chk(8'(modeState), 8'h00);
    @(posedge clock) turnOn <= 1'b1;
    waitMode(2'h1);
    waitMode(2'h2);
    chk(8'(lightLoadRefSel), 8'h00);
    rises(100, c);
    chk(c, 8'h05);
    @(posedge clock) tripCyc <= 8'h00;
    // Let the trip level settle so that a pulse begun before it is not measured.
    repeat (24) @(posedge clock);
    repeat (2) begin
      pulse(w);
      chk(w, 8'(MINON));
    end
    $display("done start and pwm");
  endtask : t_start
  task automatic t_full;
    @(posedge clock) tripCyc <= 8'hff;
    rises(30, c);
    rises(60, c);
    chk({c[6:0], driverOn}, 8'h01);
    @(posedge clock) peakCurrent <= 1'b1;
    repeat (8) @(posedge clock);
    rises(40, c);
    chk(c, 8'h02);
    @(posedge clock) peakCurrent <= 1'b0;
    tripCyc <= 8'h06;
    $display("done full duty");
  endtask : t_full
  task automatic t_pfm;
    @(posedge clock) entryThreshold <= 1'b1;
    extSyncSel <= 1'b1;
    waitMode(2'h3);
    chk(8'(lightLoadRefSel), 8'h01);
    @(posedge clock) entryThreshold <= 1'b0;
    rises(80, c);
    chk({c[6:0], stageEnable}, 8'h00);
    repeat (3) fire(40);
    chk({modeState, 5'h00, w > 8'h02 && w < 8'h05}, 8'hc1);
    repeat (4) fire(2);
    waitMode(2'h2);
    rises(40, c);
    rises(96, c);
    chk(c, 8'h06);
    $display("done pfm");
  endtask : t_pfm
  task automatic t_fault;
    @(posedge clock) supplyLow <= 1'b1;
    waitMode(2'h0);
    rises(40, c);
    chk(c, 8'h00);
    @(posedge clock) supplyLow <= 1'b0;
    waitMode(2'h2);
    @(posedge clock) entryThreshold <= 1'b1;
    waitMode(2'h3);
    @(posedge clock) thermalTrip <= 1'b1;
    entryThreshold <= 1'b0;
    waitMode(2'h0);
    @(posedge clock) thermalTrip <= 1'b0;
    waitMode(2'h1);
    chk(8'(lightLoadRefSel), 8'h00);
    waitMode(2'h2);
    @(posedge clock) turnOn <= 1'b0;
    waitMode(2'h0);
    $display("done faults");
  endtask : t_fault
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_start();
    t_full();
    t_pfm();
    t_fault();
    end_of_test();
  end
endmodule : bpm_mode_ctrl_tb
